// >>> aef_energy_accum.sv
// Active energy accumulator with divider, clear-on-read port and pulse output
//
// Notes on behaviour
// RULE1 - Each power sample is added into a hidden 54-bit accumulator while running.
// RULE2 - The readable energy is the top 24 bits of the divided accumulator.
// RULE3 - The accumulator is divided by the 8-bit divider, where zero acts as one.
// RULE4 - A new sample is added once every four clock periods.
// RULE5 - Addition is signed so negative samples lower the energy.
// RULE6 - Reading the clearing port returns the energy and then zeroes the accumulator.
// RULE7 - Reading the plain port returns the energy and leaves the accumulator alone.
// RULE8 - The readable energy wraps from the top positive code to the most negative and back.
// RULE9 - Reaching half of full scale in either direction raises the interrupt when enabled.
// RULE10 - Every one-LSB step of the readable energy makes one internal converter pulse.
// RULE11 - One output pulse leaves per denominator-over-numerator internal pulses.
// RULE12 - Numerator and denominator are 12-bit unsigned settings.
// RULE13 - A zero numerator or denominator is applied as one.
// RULE14 - Software keeps the numerator below the denominator for a steady output rate.
// RULE15 - Bits 12 to 14 of the numerator read back the per-phase negative power signs.
// RULE16 - Each output pulse is high for a fixed number of clock cycles.
// RULE17 - Half-full and wrap flags stay set until software clears them.
`timescale 1ns/1ps
`include "aef_cfg.svh"

module aef_energy_accum
  import aef_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic signed [`AEF_SAMPLE_W-1:0] powerSample,
  input wire logic [2:0] phaseNegative,
  input wire logic [`AEF_ADDR_W-1:0] regAddr,
  input wire logic [`AEF_DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [`AEF_DATA_W-1:0] regRdData,
  output logic irq,
  output logic calibrationPulseOut
);

  localparam int PulseCycles = `AEF_PULSE_CYCLES;

  // Register file
  logic [`AEF_DIV_W-1:0] energyDivider;
  logic [`AEF_FREQ_W-1:0] freqNumerator;
  logic [`AEF_FREQ_W-1:0] freqDenominator;
  logic [`AEF_EVT_W-1:0] intStatus;
  logic [`AEF_EVT_W-1:0] intMask;

  // Datapath state
  logic signed [`AEF_ACC_W-1:0] energyAcc;
  logic [1:0] sampleDiv;
  logic sampleTick;
  logic [`AEF_EXPOSED_W-1:0] prevExposed;
  logic clearedLast;
  logic [`AEF_FREQ_W:0] dfcFrac;
  logic [3:0] pendingPulses;
  logic [4:0] pulseCnt;
  aef_pulse_state_t pulseState;

  // Bus decode
  wire wrDivider = regWrStrobe && (regAddr == `AEF_ADDR_DIVIDER);
  wire wrNumerator = regWrStrobe && (regAddr == `AEF_ADDR_NUMERATOR);
  wire wrDenominator = regWrStrobe && (regAddr == `AEF_ADDR_DENOMINATOR);
  wire wrStatus = regWrStrobe && (regAddr == `AEF_ADDR_STATUS);
  wire wrMask = regWrStrobe && (regAddr == `AEF_ADDR_MASK);
  wire rdEnergy = regRdStrobe && (regAddr == `AEF_ADDR_ENERGY);
  wire rdEnergyClr = regRdStrobe && (regAddr == `AEF_ADDR_ENERGY_CLR);

  // Divide and expose upper bits
  wire [`AEF_DIV_W-1:0] divEff = (energyDivider == 8'h00) ? 8'h01 : energyDivider; // see RULE3
  wire signed [`AEF_ACC_W-1:0] divQuot = energyAcc / $signed({1'b0, divEff}); // see RULE3
  wire [`AEF_EXPOSED_W-1:0] exposed = divQuot[`AEF_ACC_W-1:`AEF_EXPOSED_LSB]; // see RULE2

  // Accumulate, clear read wins over held value
  wire signed [`AEF_ACC_W-1:0] sampleExt = `AEF_ACC_W'(powerSample);
  wire signed [`AEF_ACC_W-1:0] accBase = rdEnergyClr ? '0 : energyAcc; // see RULE6
  wire signed [`AEF_ACC_W-1:0] next_energyAcc =
    sampleTick ? accBase + sampleExt : accBase; // see RULE1 see RULE5

  // Events from the exposed top bits
  wire [1:0] prevTop = prevExposed[`AEF_EXPOSED_W-1:`AEF_EXPOSED_W-2];
  wire [1:0] curTop = exposed[`AEF_EXPOSED_W-1:`AEF_EXPOSED_W-2];
  wire valueStep = !clearedLast && (exposed != prevExposed);
  wire halfEvent = valueStep && (((prevTop == 2'h0) && (curTop == 2'h1)) ||
                   ((prevTop == 2'h3) && (curTop == 2'h2))); // see RULE9
  wire wrapEvent = valueStep && (((prevTop == 2'h1) && (curTop == 2'h2)) ||
                   ((prevTop == 2'h2) && (curTop == 2'h1))); // see RULE8
  wire [`AEF_EVT_W-1:0] evtSet = {wrapEvent, halfEvent};
  wire [`AEF_EVT_W-1:0] evtClr = wrStatus ? regWrData[`AEF_EVT_W-1:0] : '0;
  wire [`AEF_EVT_W-1:0] next_intStatus = (intStatus & ~evtClr) | evtSet; // see RULE17

  // Digital-to-frequency converter
  wire dfcTick = valueStep; // see RULE10
  wire [`AEF_FREQ_W-1:0] numEff = (freqNumerator == 12'h000) ? 12'h001 : freqNumerator;
  wire [`AEF_FREQ_W-1:0] denEff = (freqDenominator == 12'h000) ? 12'h001 : freqDenominator;
  wire [`AEF_FREQ_W:0] fracSum = dfcFrac + {1'b0, numEff}; // see RULE11
  wire fracWrap = fracSum >= {1'b0, denEff}; // see RULE11
  wire [`AEF_FREQ_W:0] next_dfcFrac = !dfcTick ? dfcFrac :
    (fracWrap ? fracSum - {1'b0, denEff} : fracSum);
  wire outRequest = dfcTick && fracWrap;
  wire pulseStart = (pulseState == AEF_PULSE_IDLE) && (pendingPulses != 4'h0);
  wire pendingFull = pendingPulses == 4'hf;
  wire [3:0] next_pendingPulses = pendingPulses + 4'((outRequest && !pendingFull) ? 1 : 0)
    - 4'(pulseStart ? 1 : 0);

  // Read mux
  wire [`AEF_DATA_W-1:0] readMux =
    (rdEnergy || rdEnergyClr) ? exposed : // see RULE6 see RULE7
    (regAddr == `AEF_ADDR_DIVIDER) ? `AEF_DATA_W'(energyDivider) :
    (regAddr == `AEF_ADDR_NUMERATOR) ?
      `AEF_DATA_W'({phaseNegative, freqNumerator}) : // see RULE15
    (regAddr == `AEF_ADDR_DENOMINATOR) ? `AEF_DATA_W'(freqDenominator) :
    (regAddr == `AEF_ADDR_STATUS) ? `AEF_DATA_W'(intStatus) :
    (regAddr == `AEF_ADDR_MASK) ? `AEF_DATA_W'(intMask) : '0;

  // Sample rate enable, one tick per four clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampleDiv <= 2'h0;
      sampleTick <= 1'b0;
    end else begin
      sampleDiv <= sampleDiv + 2'h1;
      sampleTick <= (sampleDiv == 2'(`AEF_SAMPLE_PERIOD - 2)); // see RULE4
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      energyAcc <= '0;
      prevExposed <= '0;
      clearedLast <= 1'b0;
    end else begin
      energyAcc <= next_energyAcc;
      prevExposed <= exposed;
      clearedLast <= rdEnergyClr;
    end
  end

  // Writable settings
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      energyDivider <= `AEF_RST_DIVIDER;
      freqNumerator <= `AEF_RST_FREQ;
      freqDenominator <= `AEF_RST_FREQ;
      intMask <= `AEF_RST_MASK;
    end else begin
      if (wrDivider) begin
        energyDivider <= regWrData[`AEF_DIV_W-1:0];
      end
      if (wrNumerator) begin
        freqNumerator <= regWrData[`AEF_FREQ_W-1:0]; // see RULE12
      end
      if (wrDenominator) begin
        freqDenominator <= regWrData[`AEF_FREQ_W-1:0]; // see RULE12
      end
      if (wrMask) begin
        intMask <= regWrData[`AEF_EVT_W-1:0];
      end
    end
  end

  // Status, interrupt and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intStatus <= '0;
      irq <= 1'b0;
      regRdData <= '0;
    end else begin
      intStatus <= next_intStatus;
      irq <= |(next_intStatus & intMask); // see RULE9
      if (regRdStrobe) begin
        regRdData <= readMux;
      end
    end
  end

  // Converter fraction and pending pulse count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dfcFrac <= '0;
      pendingPulses <= 4'h0;
    end else begin
      dfcFrac <= next_dfcFrac;
      pendingPulses <= next_pendingPulses;
    end
  end

  // Fixed-width output pulse with at least two low cycles between pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulseState <= AEF_PULSE_IDLE;
      pulseCnt <= 5'h00;
      calibrationPulseOut <= 1'b0;
    end else begin
      unique case (pulseState)
        AEF_PULSE_IDLE: begin
          if (pulseStart) begin
            pulseState <= AEF_PULSE_HIGH;
            pulseCnt <= 5'(PulseCycles - 1); // see RULE16
            calibrationPulseOut <= 1'b1;
          end
        end
        AEF_PULSE_HIGH: begin
          if (pulseCnt == 5'h00) begin
            pulseState <= AEF_PULSE_GAP;
            calibrationPulseOut <= 1'b0;
          end else begin
            pulseCnt <= pulseCnt - 5'h01;
          end
        end
        AEF_PULSE_GAP: begin
          pulseState <= AEF_PULSE_IDLE;
        end
        default: begin
          pulseState <= AEF_PULSE_IDLE;
          calibrationPulseOut <= 1'b0;
        end
      endcase
    end
  end

  // Checks
  chk_sample_period: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
    $rose(sampleTick) |=> !sampleTick [*3] ##1 sampleTick)
    else $error("sample tick not every four cycles");

  chk_signed_add: assert property (@(posedge clk) disable iff (sys_rst) // see RULE5
    (sampleTick && !rdEnergyClr) |=>
      energyAcc == $past(energyAcc) + $past(sampleExt))
    else $error("accumulator did not add signed sample");

  chk_acc_hold: assert property (@(posedge clk) disable iff (sys_rst) // see RULE1
    (!sampleTick && !rdEnergyClr) |=> $stable(energyAcc))
    else $error("accumulator changed without sample tick");

  chk_clear_read: assert property (@(posedge clk) disable iff (sys_rst) // see RULE6
    (rdEnergyClr && !sampleTick) |=>
      (energyAcc == '0) && (regRdData == $past(exposed)))
    else $error("clearing read did not zero accumulator");

  chk_plain_read: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
    (rdEnergy && !sampleTick) |=>
      (energyAcc == $past(energyAcc)) && (regRdData == $past(exposed)))
    else $error("plain read disturbed accumulator");

  chk_zero_divider: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
    (energyDivider == 8'h00) |-> (exposed == energyAcc[`AEF_ACC_W-1:`AEF_EXPOSED_LSB]))
    else $error("zero divider not treated as one");

  chk_zero_ratio: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
    (freqNumerator == 12'h000 || freqDenominator == 12'h000) |->
      ((freqNumerator == 12'h000) ? numEff == 12'h001 : denEff == 12'h001))
    else $error("zero scaling setting not applied as one");

  chk_pulse_width: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    $rose(calibrationPulseOut) |->
      calibrationPulseOut [*8] ##12 calibrationPulseOut ##1 !calibrationPulseOut)
    else $error("output pulse width wrong");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
    (intStatus[`AEF_EVT_HALF] && !(wrStatus && regWrData[`AEF_EVT_HALF])) |=>
      intStatus[`AEF_EVT_HALF])
    else $error("half-full flag dropped without clear");

  chk_irq_follows: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
    halfEvent && intMask[`AEF_EVT_HALF] && !wrMask |=> irq && intStatus[`AEF_EVT_HALF])
    else $error("half-full event did not raise interrupt");

  chk_sign_readback: assert property (@(posedge clk) disable iff (sys_rst) // see RULE15
    (regRdStrobe && regAddr == `AEF_ADDR_NUMERATOR) |=>
      regRdData[`AEF_SIGN_LSB+2:`AEF_SIGN_LSB] == $past(phaseNegative))
    else $error("phase sign bits not read back");

  chk_clear_tick: assert property (@(posedge clk) disable iff (sys_rst) // see RULE6
    (rdEnergyClr && sampleTick) |=> energyAcc == $past(sampleExt))
    else $error("clearing read with sample tick lost the sample");

  chk_half_set: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
    halfEvent |=> intStatus[`AEF_EVT_HALF])
    else $error("half-full event not latched");

  chk_wrap_set: assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
    wrapEvent |=> intStatus[`AEF_EVT_WRAP])
    else $error("wrap event not latched");

  chk_wrap_sticky: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
    (intStatus[`AEF_EVT_WRAP] && !(wrStatus && regWrData[`AEF_EVT_WRAP])) |=>
      intStatus[`AEF_EVT_WRAP])
    else $error("wrap flag dropped without clear");

  chk_half_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
    (wrStatus && regWrData[`AEF_EVT_HALF] && !halfEvent) |=> !intStatus[`AEF_EVT_HALF])
    else $error("half-full flag not cleared by write");

  chk_wrap_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
    (wrStatus && regWrData[`AEF_EVT_WRAP] && !wrapEvent) |=> !intStatus[`AEF_EVT_WRAP])
    else $error("wrap flag not cleared by write");

  chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
    1'b1 |=> (irq == |(intStatus & $past(intMask))))
    else $error("interrupt level does not follow unmasked status");

  chk_read_hold: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
    !regRdStrobe |=> $stable(regRdData))
    else $error("read data changed without read strobe");

  chk_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
    (regRdStrobe && (regAddr > `AEF_ADDR_MASK)) |=> (regRdData == '0))
    else $error("unmapped address did not read zero");

  chk_div_write: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
    wrDivider |=> (energyDivider == $past(regWrData[`AEF_DIV_W-1:0])))
    else $error("divider write not taken");

  chk_num_write: assert property (@(posedge clk) disable iff (sys_rst) // see RULE12
    wrNumerator |=> (freqNumerator == $past(regWrData[`AEF_FREQ_W-1:0])))
    else $error("numerator write not taken");

  chk_den_write: assert property (@(posedge clk) disable iff (sys_rst) // see RULE12
    wrDenominator |=> (freqDenominator == $past(regWrData[`AEF_FREQ_W-1:0])))
    else $error("denominator write not taken");

  chk_equal_ratio: assert property (@(posedge clk) disable iff (sys_rst) // see RULE11
    (dfcTick && (numEff == denEff)) |-> fracWrap)
    else $error("unity ratio did not pass every converter pulse");

  chk_pulse_queued: assert property (@(posedge clk) disable iff (sys_rst) // see RULE11
    (outRequest && !pendingFull) |=> (pendingPulses != 4'h0))
    else $error("output pulse request was lost");

  chk_pulse_gap: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    $fell(calibrationPulseOut) |=> !calibrationPulseOut)
    else $error("no low cycle between output pulses");

  chk_idle_low: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    (pulseState != AEF_PULSE_HIGH) |=> (pulseState == AEF_PULSE_HIGH) || !calibrationPulseOut)
    else $error("output high outside a pulse");

endmodule : aef_energy_accum

// >>> aef_cfg.svh
// Offsets, field positions, reset values and timing counts of the energy block
`ifndef AEF_CFG_SVH
`define AEF_CFG_SVH

`define AEF_ACC_W 54
`define AEF_SAMPLE_W 28
`define AEF_EXPOSED_W 24
`define AEF_EXPOSED_LSB 30
`define AEF_DIV_W 8
`define AEF_FREQ_W 12
`define AEF_ADDR_W 4
`define AEF_DATA_W 24

`define AEF_ADDR_ENERGY 4'h0
`define AEF_ADDR_ENERGY_CLR 4'h1
`define AEF_ADDR_DIVIDER 4'h2
`define AEF_ADDR_NUMERATOR 4'h3
`define AEF_ADDR_DENOMINATOR 4'h4
`define AEF_ADDR_STATUS 4'h5
`define AEF_ADDR_MASK 4'h6

`define AEF_SIGN_LSB 12
`define AEF_EVT_HALF 0
`define AEF_EVT_WRAP 1
`define AEF_EVT_W 2

`define AEF_RST_DIVIDER 8'h00
`define AEF_RST_FREQ 12'h000
`define AEF_RST_MASK 2'h0

`define AEF_SAMPLE_PERIOD 4
`define AEF_CLK_PERIOD_PS 4000
`define AEF_PULSE_NS 80
`define AEF_PULSE_CYCLES ((`AEF_PULSE_NS * 1000 + `AEF_CLK_PERIOD_PS - 1) / `AEF_CLK_PERIOD_PS)

`endif

// >>> aef_pkg.sv
// Types shared by the energy accumulator block
package aef_pkg;

  typedef enum logic [1:0] {
    AEF_PULSE_IDLE,
    AEF_PULSE_HIGH,
    AEF_PULSE_GAP
  } aef_pulse_state_t;

  typedef logic [3:0] aef_addr_t;

endpackage : aef_pkg

// >>> aef_pulse_counter.sv
// Calibration equipment model that counts output pulses
`timescale 1ns/1ps

module aef_pulse_counter (
  input wire logic clk,
  input wire logic pulseIn,
  output int pulseCount,
  output int lastWidth
);
  int count = 0;
  int width = 0;
  int widthLast = 0;
  logic prev = 1'b0;

  assign pulseCount = count;
  assign lastWidth = widthLast;

  // Whole pulses only: counted on the falling side
  always @(posedge clk) begin
    prev <= pulseIn;
    if (pulseIn) begin
      width <= width + 1;
    end else if (prev) begin
      count <= count + 1;
      widthLast <= width;
      width <= 0;
    end
  end
endmodule : aef_pulse_counter

// >>> tb_active_energy_accumulator_freq_out.sv
// Self-checking bench for the energy accumulator and pulse output
`timescale 1ns/1ps
`include "aef_cfg.svh"

module tb_active_energy_accumulator_freq_out
  import aef_pkg::*;
;
  logic clk = 1'b0;
  logic sysRst;
  logic signed [`AEF_SAMPLE_W-1:0] powerSample;
  logic [2:0] phaseNegative;
  aef_addr_t regAddr;
  logic [23:0] regWrData;
  logic regWrStrobe;
  logic regRdStrobe;
  logic [23:0] regRdData;
  logic irq;
  logic calibrationPulseOut;
  int pulseCount;
  int lastWidth;
  int errors = 0;
  int cmpCount = 0;
  int cycles = 0;
  int base;
  logic [23:0] d;
  localparam logic signed [27:0] STEP = 28'sh4000000;

  always #2 clk = ~clk;

  aef_energy_accum u_dut (
    .clk(clk),
    .sys_rst(sysRst),
    .powerSample(powerSample),
    .phaseNegative(phaseNegative),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .irq(irq),
    .calibrationPulseOut(calibrationPulseOut)
  );

  aef_pulse_counter u_meter (
    .clk(clk),
    .pulseIn(calibrationPulseOut),
    .pulseCount(pulseCount),
    .lastWidth(lastWidth)
  );

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input aef_addr_t a, input logic [23:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input aef_addr_t a, output logic [23:0] v);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1 v = regRdData;
    @(posedge clk);
  endtask : rd

  // Level held over whole tick periods gives an exact sample count
  task automatic feed(input logic signed [27:0] s, input int ticks);
    powerSample <= s;
    repeat (4 * ticks) @(posedge clk);
    powerSample <= '0;
    repeat (40) @(posedge clk);
  endtask : feed

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    powerSample = '0;
    phaseNegative = 3'h5;
    regAddr = '0;
    regWrData = '0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    sysRst = 1'b1;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    rd(`AEF_ADDR_DIVIDER, d); check(d, 24'h0);
    rd(`AEF_ADDR_NUMERATOR, d); check(d, 24'h5000);
    rd(`AEF_ADDR_DENOMINATOR, d); check(d, 24'h0);
    rd(4'h7, d); check(d, 24'h0);
    wr(`AEF_ADDR_NUMERATOR, 24'hffffff);
    rd(`AEF_ADDR_NUMERATOR, d); check(d, 24'h5fff);
    wr(`AEF_ADDR_DENOMINATOR, 24'hffffff);
    rd(`AEF_ADDR_DENOMINATOR, d); check(d, 24'h000fff);
    wr(`AEF_ADDR_DIVIDER, 24'hffffff);
    rd(`AEF_ADDR_DIVIDER, d); check(d, 24'h0000ff);
    wr(`AEF_ADDR_MASK, 24'h3);
    rd(`AEF_ADDR_MASK, d); check(d, 24'h3);
    wr(`AEF_ADDR_STATUS, 24'h3);
    rd(`AEF_ADDR_STATUS, d); check(d, 24'h0);
    check({23'h0, irq}, 24'h0);
    wr(`AEF_ADDR_ENERGY, 24'h123456);
    wr(`AEF_ADDR_NUMERATOR, 24'h1);
    wr(`AEF_ADDR_DENOMINATOR, 24'h1);
    wr(`AEF_ADDR_DIVIDER, 24'h0);
    rd(`AEF_ADDR_ENERGY_CLR, d); check(d, 24'h0);
    base = pulseCount;
    feed(STEP, 32);
    rd(`AEF_ADDR_ENERGY, d); check(d, 24'h2);
    rd(`AEF_ADDR_ENERGY, d); check(d, 24'h2);
    check(24'(pulseCount - base), 24'h2);
    check(24'(lastWidth), 24'(`AEF_PULSE_CYCLES));
    feed(-STEP, 48);
    rd(`AEF_ADDR_ENERGY, d); check(d, 24'hffffff);
    rd(`AEF_ADDR_ENERGY_CLR, d); check(d, 24'hffffff);
    rd(`AEF_ADDR_ENERGY, d); check(d, 24'h0);
    wr(`AEF_ADDR_DIVIDER, 24'h2);
    feed(STEP, 64);
    rd(`AEF_ADDR_ENERGY_CLR, d); check(d, 24'h2);
    wr(`AEF_ADDR_DIVIDER, 24'h0);
    // Numerator kept below denominator throughout
    wr(`AEF_ADDR_NUMERATOR, 24'h0);
    wr(`AEF_ADDR_DENOMINATOR, 24'h2);
    base = pulseCount;
    feed(STEP, 64);
    check(24'(pulseCount - base), 24'h2);
    wr(`AEF_ADDR_NUMERATOR, 24'h1);
    wr(`AEF_ADDR_DENOMINATOR, 24'h3);
    base = pulseCount;
    feed(STEP, 192);
    check(24'(pulseCount - base), 24'h4);
    check(24'(lastWidth), 24'(`AEF_PULSE_CYCLES));
    give_verdict();
  end
endmodule : tb_active_energy_accumulator_freq_out
